// ==== testbench.sv ====
// Self-checking bench for the watchdog timer.
`timescale 1ns/1ps
module testbench;
	logic        core_clk = 0, rst_n = 0, clk_en = 1, hardware_arm_option = 0;
	logic        wait_mode = 0, halt_enter = 0, wake_irq = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire         s_axi_rvalid, wdg_reset_req;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	logic [33:0] q[$];
	logic [33:0] n;
	logic [33:0] pulses = 0;
	logic [15:0] sd = 16'hdb9b;
	logic [7:0]  v;
	int          num_errors = 0, samples_checked = 0;
	// A short tick keeps the run brief; all expectations assume eight.
	wwd_top #(
		.TICK_CYCLES (8),
		.WAKE_CYCLES (4)
	) dut (
		.core_clk            (core_clk),
		.rst_n               (rst_n),
		.clk_en              (clk_en),
		.hardware_arm_option (hardware_arm_option),
		.wait_mode           (wait_mode),
		.halt_enter          (halt_enter),
		.wake_irq            (wake_irq),
		.wdg_reset_req       (wdg_reset_req),
		.s_axi_awaddr        (s_axi_awaddr),
		.s_axi_awvalid       (s_axi_awvalid),
		.s_axi_awready       (s_axi_awready),
		.s_axi_wdata         (s_axi_wdata),
		.s_axi_wstrb         (s_axi_wstrb),
		.s_axi_wvalid        (s_axi_wvalid),
		.s_axi_wready        (s_axi_wready),
		.s_axi_bresp         (s_axi_bresp),
		.s_axi_bvalid        (s_axi_bvalid),
		.s_axi_bready        (s_axi_bready),
		.s_axi_araddr        (s_axi_araddr),
		.s_axi_arvalid       (s_axi_arvalid),
		.s_axi_arready       (s_axi_arready),
		.s_axi_rdata         (s_axi_rdata),
		.s_axi_rresp         (s_axi_rresp),
		.s_axi_rvalid        (s_axi_rvalid),
		.s_axi_rready        (s_axi_rready)
	);
	// The 25 MHz core clock.
	initial forever #20 core_clk = ~core_clk;
	function automatic [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input logic [33:0] s, input logic [33:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t: got %h exp %h", $time, s, e);
		end
	endtask
	// Address and data go out together; each drops once taken.
	task wr(input [11:0] a, input [7:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
	endtask
	// The expected answer is queued before the request goes out.
	task rd(input [11:0] a, input [33:0] e);
		q.push_back(e);
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
	endtask
	// Read answers are matched against the oldest note.
	always @(posedge core_clk) begin
		if (wdg_reset_req === 1'b1) pulses <= pulses + 1;
		if (s_axi_rvalid && s_axi_rready) begin
			n = q.pop_front();
			chk({s_axi_rresp, s_axi_rdata}, n);
		end
	end
	task final_report;
		$display("compares %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Cut a hang short well past the expected two thousand cycles.
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1;
		rd(12'h0d4, 34'h7f);
		rd(12'h104, 34'h0);
		rd(12'h0f0, 34'h200000000);
		repeat (64) @(posedge core_clk);
		rd(12'h0d4, 34'h7f);
		$display("test reset done");
		wr(12'h100, 8'h01);
		sd = lfsr(sd);
		v = {4'h0, sd[3:0]};
		wr(12'h0d4, v);
		// Exactly sixteen prescaler periods end before the read samples.
		repeat (128) @(posedge core_clk);
		rd(12'h0d4, {26'h0, (v - 8'h10) & 8'h7f});
		repeat (480) @(posedge core_clk);
		chk(pulses, 34'h0);
		$display("test free run done");
		wait_mode <= 1;
		wr(12'h0d4, 8'hc2);
		wr(12'h0d4, 8'h42);
		rd(12'h0d4, 34'hc2);
		repeat (40) @(posedge core_clk);
		chk(pulses, 34'h1);
		wr(12'h0d4, 8'h80);
		repeat (2) @(posedge core_clk);
		chk(pulses, 34'h2);
		$display("test expiry done");
		// The halt entry edge also carries a normal tick, then one step.
		wr(12'h0d4, 8'hc8);
		halt_enter <= 1;
		@(posedge core_clk);
		halt_enter <= 0;
		repeat (100) @(posedge core_clk);
		rd(12'h0d4, 34'hc6);
		chk(pulses, 34'h2);
		wake_irq <= 1;
		@(posedge core_clk);
		wake_irq <= 0;
		// Two ticks by now with the wake delay, and two as well without it.
		repeat (22) @(posedge core_clk);
		rd(12'h0d4, 34'hc4);
		$display("test halt done");
		// Halt again, then reset out of it with the hardware option on.
		halt_enter <= 1;
		@(posedge core_clk);
		halt_enter <= 0;
		rst_n <= 0;
		hardware_arm_option <= 1;
		repeat (5) @(posedge core_clk);
		rst_n <= 1;
		rd(12'h104, 34'h3);
		rd(12'h0d4, 34'h7f);
		repeat (530) @(posedge core_clk);
		chk(pulses, 34'h3);
		$display("test hardware option done");
		// Frozen cycles must advance neither the prescaler nor the count.
		clk_en <= 0;
		repeat (400) @(posedge core_clk);
		clk_en <= 1;
		rd(12'h0d4, 34'h3c);
		chk(pulses, 34'h3);
		$display("test clock enable done");
		final_report;
	end
endmodule

// ==== wwd_chk_asserts.sv ====
// Checker for the watchdog bus answers and reset request.
`timescale 1ns/1ps
module wwd_chk (
	input wire        core_clk,
	input wire        rst_n,
	input wire [11:0] s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0]  s_axi_wstrb,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        halt_enter,
	input wire        wdg_reset_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// A write counts once address and data meet ready together.
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_kill;
		s_wr ##0 (s_axi_awaddr == 12'h0d4 && s_axi_wstrb[0]
			&& s_axi_wdata[7:6] == 2'b10);
	endsequence
	property p_kill; s_kill |=> wdg_reset_req; endproperty
	a_kill: assert property (p_kill) else $error("no soft reset");
	property p_pulse; wdg_reset_req |=> !wdg_reset_req; endproperty
	a_pulse: assert property (p_pulse) else $error("reset too long");
	property p_halt; halt_enter |-> ##1 !wdg_reset_req [*8]; endproperty
	a_halt: assert property (p_halt) else $error("reset in halt");
	property p_b; s_wr |=> s_axi_bvalid; endproperty
	a_b: assert property (p_b) else $error("write not answered");
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bh: assert property (p_bh) else $error("bvalid dropped");
	property p_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r: assert property (p_r) else $error("read not answered");
	property p_rh;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rh: assert property (p_rh) else $error("read data moved");
	property p_bad;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0f0
			|=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
	endproperty
	a_bad: assert property (p_bad) else $error("hole not refused");
	property p_one; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_one: assert property (p_one) else $error("second read taken");
endmodule
bind wwd_top wwd_chk u_chk (
	.core_clk      (core_clk),
	.rst_n         (rst_n),
	.s_axi_awaddr  (s_axi_awaddr),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wdata   (s_axi_wdata),
	.s_axi_wstrb   (s_axi_wstrb),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_araddr  (s_axi_araddr),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rresp   (s_axi_rresp),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.halt_enter    (halt_enter),
	.wdg_reset_req (wdg_reset_req)
);

// ==== wwd_map.vh ====
// Register map, field positions and timing constants for the watchdog.
`ifndef WWD_MAP_VH
`define WWD_MAP_VH
`define WWD_CTRL_OFFSET   12'h035
`define WWD_CTRL_ADDR     12'h0d4
`define WWD_GATE_ADDR     12'h100
`define WWD_STAT_ADDR     12'h104
`define WWD_CTRL_RESET    8'h7f
`define WWD_ARM_BIT       7
`define WWD_TOP_BIT       6
`define WWD_TICK_CYCLES   131072
`define WWD_WAKE_CYCLES   512
`define WWD_COUNT_MAX     7'h7f
`define WWD_COUNT_EDGE    7'h40
`define WWD_RESP_OKAY     2'b00
`define WWD_RESP_SLVERR   2'b10
`endif

// ==== wwd_prescaler.v ====
// Prescaler that pulses once every given number of enabled cycles.
`timescale 1ns/1ps
`include "wwd_map.vh"
module wwd_prescaler #(
	parameter TICK_CYCLES = `WWD_TICK_CYCLES
) (
	input  wire core_clk,
	input  wire rst_n,
	input  wire clk_en,
	input  wire run,
	input  wire clear,
	output reg  tick
);
	// The full-width value is cut on purpose to the counter width.
	localparam [31:0] LAST_FULL = TICK_CYCLES - 1;
	localparam [17:0] LAST      = LAST_FULL[17:0];
	reg [17:0] cnt_reg;

	// The count is cleared on wake and reset so every period is whole.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_reg <= 18'h00000;
			tick    <= 1'b0;
		end else if (clk_en) begin
			tick <= 1'b0;
			if (clear) begin
				cnt_reg <= 18'h00000;
			end else if (run) begin
				if (cnt_reg == LAST) begin
					cnt_reg <= 18'h00000;
					tick    <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 18'h00001;
				end
			end
		end
	end
endmodule

// ==== wwd_top.v ====
// Windowed watchdog reset timer with an AXI4-Lite register slave.
// Behaviour
// - Count field decrements by one every 131072 machine cycles.
// - Armed and count stepping 40h to 3Fh issues a device reset.
// - Counter keeps decrementing when disarmed; disarm only suppresses reset.
// - Writing arm set with top bit clear resets the device at once.
// - Software option: disarmed after reset, arm sticks until next reset.
// - Hardware option: always armed, arm bit ignored.
// - In WAIT the watchdog runs and resets as normal.
// - Entering HALT decrements once more, then stops; no reset issued.
// - After interrupt wake from HALT, counting resumes after 512 clocks.
// - Reset out of HALT returns to disarmed state unless hardware option.
// - Control register resets to 7Fh.
// - Arm bit is set only by software and cleared only by reset.
// - Clock gate follows software enable, forced on by hardware option.
`timescale 1ns/1ps
`include "wwd_map.vh"
module wwd_top #(
	parameter TICK_CYCLES = `WWD_TICK_CYCLES,
	parameter WAKE_CYCLES = `WWD_WAKE_CYCLES
) (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        clk_en,
	input  wire        hardware_arm_option,
	input  wire        wait_mode,
	input  wire        halt_enter,
	input  wire        wake_irq,
	output reg         wdg_reset_req,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	localparam [1:0] ST_RUN  = 2'b00;
	localparam [1:0] ST_HALT = 2'b01;
	localparam [1:0] ST_WAKE = 2'b10;
	// The full-width value is cut on purpose to the wake counter width.
	localparam [31:0] WAKE_FULL = WAKE_CYCLES - 1;
	localparam [9:0]  WAKE_LAST = WAKE_FULL[9:0];

	reg        arm_reg;
	reg  [6:0] count_reg;
	reg        gate_reg;
	reg  [1:0] state_reg;
	reg  [9:0] wake_cnt_reg;
	reg        halt_step_reg;
	reg        aw_held_reg;
	reg [11:0] aw_addr_reg;
	reg        w_held_reg;
	reg [31:0] w_data_reg;
	reg  [3:0] w_strb_reg;
	wire       tick;
	wire       armed;
	wire       gate_on;
	wire       run;
	wire       wr_fire;
	wire       ctrl_wr;
	wire [6:0] count_dec;
	wire       soft_reset;
	wire       expire;

	// Lower seven bits step down; 00h naturally wraps to 7Fh.
	function [6:0] dec7;
		input [6:0] v;
		begin
			dec7 = v - 7'h01;
		end
	endfunction

	assign armed   = arm_reg | hardware_arm_option;
	assign gate_on = gate_reg | hardware_arm_option;
	// WAIT does not stop the counter; only the gate, HALT, its wake delay and a low clk_en do.
	assign run     = gate_on & (state_reg == ST_RUN);

	wwd_prescaler #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_pre (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.run      (run),
		.clear    (state_reg != ST_RUN),
		.tick     (tick)
	);

	// Write address and data may arrive in either order; each is held.
	// Readies drop while frozen so that no handshake is lost.
	assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid & clk_en;
	assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid & clk_en;
	assign wr_fire = (aw_held_reg | s_axi_awvalid) &
		(w_held_reg | s_axi_wvalid) & ~s_axi_bvalid;
	wire [11:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
	wire [3:0]  wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
	assign ctrl_wr = wr_fire & (wr_addr == `WWD_CTRL_ADDR) & wr_strb[0];

	// Arming from software with the top bit clear resets at once.
	assign soft_reset = ctrl_wr & wr_data[`WWD_ARM_BIT] &
		~wr_data[`WWD_TOP_BIT];
	assign count_dec = dec7(count_reg);
	// Expiry is the 40h to 3Fh step; HALT states never tick.
	// A refresh in the same cycle wins, so that cycle makes no 40h to 3Fh step.
	assign expire = tick & armed & ~ctrl_wr &
		(count_reg == `WWD_COUNT_EDGE);

	// Bus channel holding and write response.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			aw_held_reg  <= 1'b0;
			aw_addr_reg  <= 12'h000;
			w_held_reg   <= 1'b0;
			w_data_reg   <= 32'h00000000;
			w_strb_reg   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `WWD_RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wr_addr == `WWD_CTRL_ADDR ||
					wr_addr == `WWD_GATE_ADDR ||
					wr_addr == `WWD_STAT_ADDR) begin
					s_axi_bresp <= `WWD_RESP_OKAY;
				end else begin
					s_axi_bresp <= `WWD_RESP_SLVERR;
				end
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held_reg <= 1'b1;
					aw_addr_reg <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held_reg <= 1'b1;
					w_data_reg <= s_axi_wdata;
					w_strb_reg <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// Control register, clock gate and the counter itself.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			arm_reg   <= 1'b0;
			count_reg <= `WWD_COUNT_MAX;
			gate_reg  <= 1'b0;
		end else if (clk_en) begin
			if (ctrl_wr) begin
				// A zero in the arm bit cannot disarm.
				if (wr_data[`WWD_ARM_BIT]) begin
					arm_reg <= 1'b1;
				end
				count_reg <= wr_data[6:0];
			end else if (tick || halt_step_reg) begin
				count_reg <= count_dec;
			end
			if (wr_fire && wr_addr == `WWD_GATE_ADDR && wr_strb[0]) begin
				gate_reg <= wr_data[0];
			end
		end
	end

	// Low power sequencing: one step into HALT, then a delay after wake.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg     <= ST_RUN;
			wake_cnt_reg  <= 10'h000;
			halt_step_reg <= 1'b0;
		end else if (clk_en) begin
			halt_step_reg <= 1'b0;
			case (state_reg)
				ST_RUN: begin
					if (halt_enter) begin
						state_reg     <= ST_HALT;
						halt_step_reg <= gate_on;
					end
				end
				ST_HALT: begin
					if (wake_irq) begin
						state_reg    <= ST_WAKE;
						wake_cnt_reg <= 10'h000;
					end
				end
				ST_WAKE: begin
					if (wake_cnt_reg == WAKE_LAST) begin
						state_reg <= ST_RUN;
					end else begin
						wake_cnt_reg <= wake_cnt_reg + 10'h001;
					end
				end
				default: begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end

	// Reset request is a one-cycle pulse; the system reset then clears us.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			wdg_reset_req <= 1'b0;
		end else if (clk_en) begin
			wdg_reset_req <= expire | soft_reset;
		end
	end

	// Reads answer one cycle after the address is taken.
	assign s_axi_arready = ~s_axi_rvalid & clk_en;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `WWD_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `WWD_RESP_OKAY;
				if (s_axi_araddr == `WWD_CTRL_ADDR) begin
					s_axi_rdata <= {24'h000000, arm_reg, count_reg};
				end else if (s_axi_araddr == `WWD_GATE_ADDR) begin
					s_axi_rdata <= {31'h00000000, gate_reg};
				end else if (s_axi_araddr == `WWD_STAT_ADDR) begin
					s_axi_rdata <= {28'h0000000, state_reg, gate_on, armed};
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `WWD_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
